/* File: dv/datu_dv_pkg.sv */
// Package: page table entry contents shared by the memory model and bench
package datu_dv_pkg;
    // Entry base made from the low 48 bits of its own address, so entries whose addresses differ in those bits differ
    function automatic logic [51:0] pte_base(input logic [63:0] ea);
        return {4'h5, ea[47:0]};
    endfunction
endpackage

/* File: dv/datu_mem_model.sv */
// Partner model: host memory answering page table entry fetches
`timescale 1ns/1ps
`default_nettype none
module datu_mem_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        rd_req_valid,
    input  wire logic [63:0] rd_req_addr,
    output logic             rd_req_ready,
    output logic             rd_rsp_valid,
    output logic [63:0]      rd_rsp_data,
    output logic [15:0]      fetch_cnt,
    output logic [63:0]      last_addr
);
    logic [63:0] ta;

    // ------------------------------------------------------------
    // Fetch responder
    // ------------------------------------------------------------
    initial begin
        rd_req_ready = 1'b0;
        rd_rsp_valid = 1'b0;
        rd_rsp_data  = 64'hA5A5_5A5A_C3C3_3C3C;
        fetch_cnt    = 16'h0000;
        last_addr    = 64'h0000_0000_0000_0000;
        forever begin
            @(posedge clk);
            if (rstn && rd_req_valid) begin
                // Address is held until ready, so it is safe to take now
                ta = rd_req_addr;
                repeat (slow ? 3 : 0) @(posedge clk);
                rd_req_ready <= 1'b1;
                @(posedge clk);
                rd_req_ready <= 1'b0;
                last_addr    <= ta;
                for (int i = 0; i < 8; i++) begin
                    if (slow) begin
                        // Idle data keeps moving so a stale read shows up
                        rd_rsp_valid <= 1'b0;
                        rd_rsp_data  <= ~rd_rsp_data;
                        @(posedge clk);
                    end
                    rd_rsp_valid <= 1'b1;
                    rd_rsp_data  <= {datu_dv_pkg::pte_base(ta + 64'(i * 8)),
                                     12'h000};
                    @(posedge clk);
                end
                rd_rsp_valid <= 1'b0;
                rd_rsp_data  <= ~rd_rsp_data;
                fetch_cnt    <= fetch_cnt + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Testbench: self-checking scenarios for the address translation unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
    checked++; \
    if ((got) !== (ex)) begin \
        fail_count++; \
        $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
end
module testbench;
    logic                       clk, rstn, addr32_mode, slow;
    logic [7:0]                 tc_map_en, tc_route_sel;
    logic                       ptp_wr_en;
    logic [3:0]                 ptp_wr_ch;
    logic [2:0]                 ptp_wr_buf;
    logic [51:0]                ptp_wr_base;
    logic                       in_valid, in_ready, out_valid, out_ready;
    datu_pkg::datu_in_pkt_type  in_pkt;
    datu_pkg::datu_out_pkt_type out_pkt;
    logic                       rd_req_valid, rd_req_ready, rd_rsp_valid;
    logic [63:0]                rd_req_addr, rd_rsp_data, last_addr;
    logic                       drop_event;
    logic [15:0]                fetch_cnt;
    logic [51:0]                ptp_tab [16][8] = '{default: '0};
    int                         fail_count = 0;
    int                         checked = 0;

    datu_top uut (.clk(clk), .rstn(rstn), .addr32_mode(addr32_mode),
        .tc_map_en(tc_map_en), .tc_route_sel(tc_route_sel),
        .ptp_wr_en(ptp_wr_en), .ptp_wr_ch(ptp_wr_ch), .ptp_wr_buf(ptp_wr_buf),
        .ptp_wr_base(ptp_wr_base), .in_valid(in_valid), .in_pkt(in_pkt),
        .in_ready(in_ready), .out_valid(out_valid), .out_pkt(out_pkt),
        .out_ready(out_ready), .rd_req_valid(rd_req_valid),
        .rd_req_addr(rd_req_addr), .rd_req_ready(rd_req_ready),
        .rd_rsp_valid(rd_rsp_valid), .rd_rsp_data(rd_rsp_data),
        .drop_event(drop_event));
    datu_mem_model mem (.clk(clk), .rstn(rstn), .slow(slow),
        .rd_req_valid(rd_req_valid), .rd_req_addr(rd_req_addr),
        .rd_req_ready(rd_req_ready), .rd_rsp_valid(rd_rsp_valid),
        .rd_rsp_data(rd_rsp_data), .fetch_cnt(fetch_cnt),
        .last_addr(last_addr));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report;
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic hang(input string nm);
        fail_count++;
        $display("ERROR %s expected done seen timeout", nm);
        final_report();
    endtask

    task automatic write_ptp(input logic [3:0] ch, input logic [2:0] b,
                             input logic [51:0] base);
        @(negedge clk);
        ptp_wr_en   = 1'b1;
        ptp_wr_ch   = ch;
        ptp_wr_buf  = b;
        ptp_wr_base = base;
        ptp_tab[ch][b] = base;
        @(negedge clk);
        ptp_wr_en = 1'b0;
    endtask

    // One packet through the unit; a miss expects exactly one fetch
    task automatic send_pkt(input logic [3:0] ch, input logic [31:0] la,
                            input logic [2:0] tc, input bit miss, stall);
        logic [63:0] ta, pa;
        logic [15:0] f0;
        int          n;
        ta = {ptp_tab[ch][la[23:21]], la[20:15], 6'h00};
        if (addr32_mode) ta[63:32] = 32'h0000_0000;
        pa = {datu_dv_pkg::pte_base({ta[63:6], la[14:12], 3'h0}), la[11:0]};
        if (addr32_mode) pa[63:32] = 32'h0000_0000;
        f0 = fetch_cnt;
        @(negedge clk);
        out_ready = !stall;
        in_valid  = 1'b1;
        in_pkt = '{vch: ch, laddr: la, tc: tc, data: {la, ~la}, last: la[0]};
        n = 0;
        while (in_ready !== 1'b1) begin
            if (++n > 50) hang("in_ready");
            @(negedge clk);
        end
        @(negedge clk);
        in_valid = 1'b0;
        n = 0;
        while (out_valid !== 1'b1 && drop_event !== 1'b1) begin
            if (++n > 200) hang("answer");
            @(negedge clk);
        end
        if (!tc_map_en[tc]) begin
            `CHK("drop", 2'b01, {out_valid, drop_event})
        end else begin
            `CHK("fetch count", f0 + 16'(miss), fetch_cnt)
            if (miss) `CHK("table addr", ta, last_addr)
            `CHK("paddr", pa, out_pkt.paddr)
            `CHK("route", tc_route_sel[tc], out_pkt.route)
            `CHK("data", {la, ~la}, out_pkt.data)
            `CHK("tc last", {tc, la[0]}, {out_pkt.tc, out_pkt.last})
            if (stall) begin
                repeat (3) @(negedge clk);
                `CHK("held", {1'b1, pa}, {out_valid, out_pkt.paddr})
                out_ready = 1'b1;
            end
        end
        @(negedge clk);
        `CHK("released", 2'b00, {out_valid, drop_event})
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [3:0] outs;
        outs = {in_ready, out_valid, rd_req_valid, drop_event};
        `CHK("reset outs", 4'h0, outs)
        rstn = 1'b1;
        @(negedge clk);
        `CHK("in_ready", 1'b1, in_ready)
    endtask

    task automatic t_translate;
        send_pkt(4'h0, 32'h0000_1004, 3'h0, 1'b1, 1'b0);
        write_ptp(4'h3, 3'h1, 52'h1_2345_6789_ABCD);
        write_ptp(4'h3, 3'h2, 52'h0_0000_0004_1000);
        send_pkt(4'h3, 32'h0022_A123, 3'h0, 1'b1, 1'b0);
        send_pkt(4'h3, 32'h0022_FFFF, 3'h1, 1'b0, 1'b0);
        send_pkt(4'h3, 32'h0022_8000, 3'h2, 1'b0, 1'b1);
    endtask

    task automatic t_buf_switch;
        send_pkt(4'h3, 32'h0042_A123, 3'h0, 1'b1, 1'b0);
        send_pkt(4'h3, 32'h0022_A123, 3'h0, 1'b1, 1'b0);
    endtask

    task automatic t_tc;
        for (int t = 0; t < 8; t++) begin
            send_pkt(4'h3, 32'h0022_A100 + 32'(t), 3'(t), 1'b0,
                     1'b0);
        end
    endtask

    task automatic t_large_slow;
        slow = 1'b1;
        write_ptp(4'hF, 3'h0, 52'hF_0000_8000_0000);
        send_pkt(4'hF, 32'h0000_7FFC, 3'h0, 1'b1, 1'b0);
        slow = 1'b0;
    endtask

    task automatic t_legacy;
        addr32_mode = 1'b1;
        write_ptp(4'h3, 3'h1, 52'h1_2345_6789_ABCD);
        send_pkt(4'h3, 32'h0022_A123, 3'h0, 1'b1, 1'b0);
        addr32_mode = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        addr32_mode = 1'b0;
        slow = 1'b0;
        tc_map_en = 8'hB7;
        tc_route_sel = 8'h53;
        ptp_wr_en = 1'b0;
        ptp_wr_ch = 4'h0;
        ptp_wr_buf = 3'h0;
        ptp_wr_base = '0;
        in_valid = 1'b0;
        in_pkt = '0;
        out_ready = 1'b1;
        repeat (6) @(negedge clk);
        t_reset();
        t_translate();
        t_buf_switch();
        t_tc();
        t_large_slow();
        t_legacy();
        final_report();
    end
endmodule
`default_nettype wire

/* File: logic/datu_pkg.sv */
// Package: constants and carriers for the DMA address translation unit
package datu_pkg;
    localparam int NUM_PHYS_CH = 12;
    localparam int NUM_VCH     = 16;
    localparam int VCH_W       = 4;
    localparam int NUM_BUF     = 8;
    localparam int BUF_W       = 3;
    localparam int LADDR_W     = 32;
    localparam int PADDR_W     = 64;
    localparam int LEGACY_W    = 32;
    localparam int PAGE_OFS_W  = 12;
    localparam int BASE_W      = PADDR_W - PAGE_OFS_W;
    localparam int PTE_BYTES   = 8;
    localparam int PTE_IDX_W   = 9;
    localparam int PF_N        = 8;
    localparam int PF_IDX_W    = 3;
    localparam int WIN_W       = PTE_IDX_W - PF_IDX_W;
    localparam int WIN_LSB     = PAGE_OFS_W + PF_IDX_W;
    localparam int BUF_LSB     = PAGE_OFS_W + PTE_IDX_W;
    localparam int WIN_SHIFT   = 6;
    localparam int TC_W        = 3;
    localparam int NUM_TC      = 8;
    localparam int DATA_W      = 64;

    typedef struct packed {
        logic [VCH_W-1:0]   vch;
        logic [LADDR_W-1:0] laddr;
        logic [TC_W-1:0]    tc;
        logic [DATA_W-1:0]  data;
        logic               last;
    } datu_in_pkt_type;

    typedef struct packed {
        logic [PADDR_W-1:0] paddr;
        logic [TC_W-1:0]    tc;
        logic               route;
        logic [DATA_W-1:0]  data;
        logic               last;
    } datu_out_pkt_type;

    typedef struct packed {
        logic [BUF_W-1:0] buf_num;
        logic [WIN_W-1:0] win;
    } datu_tag_type;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CHECK = 3'b001,
        S_REQ   = 3'b010,
        S_FILL  = 3'b011,
        S_SEND  = 3'b100
    } datu_state_type;
endpackage

/* File: logic/datu_pte_window.sv */
// Module: pre-fetched page table entry window of one channel
`timescale 1ns/1ps
`default_nettype none
module datu_pte_window #(
    parameter int ENTRIES = datu_pkg::PF_N,
    parameter int IDX_W   = datu_pkg::PF_IDX_W,
    parameter int ENTRY_W = datu_pkg::BASE_W
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 inval,
    input  wire logic                 fill_en,
    input  wire logic [IDX_W-1:0]     fill_idx,
    input  wire logic [ENTRY_W-1:0]   fill_data,
    input  wire logic                 fill_done,
    input  wire datu_pkg::datu_tag_type fill_tag,
    input  wire logic [IDX_W-1:0]     rd_idx,
    output logic [ENTRY_W-1:0]        rd_data,
    output datu_pkg::datu_tag_type    tag_q,
    output logic                      valid_q
);
    logic [ENTRY_W-1:0] entry_q [ENTRIES];

    // ------------------------------------------------------------
    // Entry storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (fill_en) begin
            entry_q[fill_idx] <= fill_data;
        end
    end

    assign rd_data = entry_q[rd_idx];

    // ------------------------------------------------------------
    // Tag and valid; a refill drops the old set on the edge that writes the first beat
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            valid_q <= 1'b0;
            tag_q   <= '0;
        end else if (inval || (fill_en && fill_idx == '0)) begin
            valid_q <= 1'b0;
        end else if (fill_done) begin
            valid_q <= 1'b1;
            tag_q   <= fill_tag;
        end
    end
endmodule
`default_nettype wire

/* File: logic/datu_top.sv */
// Module: DMA address translation unit, logical to physical mapping
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Each packet leaves with its 32-bit logical address mapped to 64 bits.
// R2: A legacy option clears the upper 32 address bits for 32-bit hosts.
// R3: Packets from all twelve DMA channels are taken, keeping their source. The output packet carries no channel number.
// R4: Eight table pointers per channel, picked by channel and buffer number.
// R5: Software places each page table as a 4 kB region on a 4 kB boundary.
// R6: Each entry is the base of a 4 kB page; the in-page offset is added.
// R7: Entries are 8 bytes each, so one table maps a buffer of at most 2 MB.
// R8: Eight page table entries are pre-fetched and held to keep latency low.
// R9: On a buffer change the channel's whole pre-fetched set is replaced.
// R10: The buffer number is taken from bits of the packet's virtual address.
// R11: Sixteen virtual channel numbers are taken; spares serve large buffers.
// R12: Translated packets leave on a route chosen by their traffic class.
// R13: A packet of an unmapped traffic class is dropped and an event raised.
// R14: Software may enable one buffer per channel but should use at least two.
// R15: While entries are fetched the channel's packet waits untranslated.
module datu_top (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            addr32_mode,
    input  wire logic [datu_pkg::NUM_TC-1:0]     tc_map_en,
    input  wire logic [datu_pkg::NUM_TC-1:0]     tc_route_sel,
    input  wire logic                            ptp_wr_en,
    input  wire logic [datu_pkg::VCH_W-1:0]      ptp_wr_ch,
    input  wire logic [datu_pkg::BUF_W-1:0]      ptp_wr_buf,
    input  wire logic [datu_pkg::BASE_W-1:0]     ptp_wr_base,
    input  wire logic                            in_valid,
    input  wire datu_pkg::datu_in_pkt_type       in_pkt,
    output logic                                 in_ready,
    output logic                                 out_valid,
    output datu_pkg::datu_out_pkt_type           out_pkt,
    input  wire logic                            out_ready,
    output logic                                 rd_req_valid,
    output logic [datu_pkg::PADDR_W-1:0]         rd_req_addr,
    input  wire logic                            rd_req_ready,
    input  wire logic                            rd_rsp_valid,
    input  wire logic [datu_pkg::PADDR_W-1:0]    rd_rsp_data,
    output logic                                 drop_event
);
    localparam int NV = datu_pkg::NUM_VCH;
    localparam int NB = datu_pkg::NUM_BUF;
    localparam int BW = datu_pkg::BASE_W;

    default clocking d_clk @(posedge clk);
    endclocking
    default disable iff (!rstn);

    datu_pkg::datu_state_type         state_q;
    datu_pkg::datu_in_pkt_type        pkt_q;
    datu_pkg::datu_out_pkt_type       out_q;
    datu_pkg::datu_tag_type           need_tag;
    datu_pkg::datu_tag_type           win_tag [NV];
    logic [NV-1:0]                    win_valid;
    logic [BW-1:0]                    win_data [NV];
    logic [BW-1:0]                    ptp_q [NV][NB];
    logic [datu_pkg::PF_IDX_W-1:0]    fill_cnt_q;
    logic [datu_pkg::PF_IDX_W-1:0]    pte_sel;
    logic                             in_ready_q;
    logic                             rd_req_valid_q;
    logic [datu_pkg::PADDR_W-1:0]     rd_req_addr_q;
    logic                             drop_q;
    logic                             hit;
    logic                             mapped;
    logic [datu_pkg::PADDR_W-1:0]     paddr;
    logic [datu_pkg::PADDR_W-1:0]     pt_addr;
    logic                             fill_last;

    // ------------------------------------------------------------
    // Lookup of the current packet
    // ------------------------------------------------------------
    // Buffer number and window come from the virtual address [R10]
    assign need_tag.buf_num = pkt_q.laddr[datu_pkg::BUF_LSB +: datu_pkg::BUF_W];
    assign need_tag.win     = pkt_q.laddr[datu_pkg::WIN_LSB +: datu_pkg::WIN_W];
    assign pte_sel   = pkt_q.laddr[datu_pkg::PAGE_OFS_W +: datu_pkg::PF_IDX_W];
    // A tag holds the buffer, so a buffer switch is always a miss [R9]
    assign hit       = win_valid[pkt_q.vch] && (win_tag[pkt_q.vch] == need_tag);
    assign mapped    = tc_map_en[pkt_q.tc];
    assign fill_last = rd_rsp_valid && (fill_cnt_q == 3'h7);

    always_comb begin
        // Entry base plus in-page offset [R1] [R6]
        paddr = {win_data[pkt_q.vch],
                 pkt_q.laddr[datu_pkg::PAGE_OFS_W-1:0]};
        // Legacy hosts see only the low 32 bits [R2]
        if (addr32_mode) begin
            paddr[datu_pkg::PADDR_W-1:datu_pkg::LEGACY_W] = '0;
        end
        // Pointer by channel and buffer; 8-byte entries [R4] [R7]
        pt_addr = {ptp_q[pkt_q.vch][need_tag.buf_num],
                   need_tag.win, 6'h00};
        if (addr32_mode) begin
            pt_addr[datu_pkg::PADDR_W-1:datu_pkg::LEGACY_W] = '0;
        end
    end

    // ------------------------------------------------------------
    // Pointer store: all sixteen channel numbers have their own set
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int c = 0; c < NV; c++) begin
                for (int b = 0; b < NB; b++) begin
                    ptp_q[c][b] <= '0;
                end
            end
        end else if (ptp_wr_en) begin
            ptp_q[ptp_wr_ch][ptp_wr_buf] <= ptp_wr_base; // [R4] [R11]
        end
    end

    // ------------------------------------------------------------
    // Pre-fetch windows, one per channel number
    // ------------------------------------------------------------
    for (genvar g = 0; g < NV; g++) begin : g_win
        datu_pte_window u_win (
            .clk       (clk),
            .rstn      (rstn),
            // New pointer makes the held entries stale
            .inval     (ptp_wr_en && ptp_wr_ch == datu_pkg::VCH_W'(g)),
            .fill_en   (state_q == datu_pkg::S_FILL && rd_rsp_valid
                        && pkt_q.vch == datu_pkg::VCH_W'(g)),
            .fill_idx  (fill_cnt_q),
            .fill_data (rd_rsp_data[datu_pkg::PADDR_W-1:
                                    datu_pkg::PAGE_OFS_W]),
            .fill_done (state_q == datu_pkg::S_FILL && fill_last
                        && pkt_q.vch == datu_pkg::VCH_W'(g)),
            .fill_tag  (need_tag),
            .rd_idx    (pte_sel),
            .rd_data   (win_data[g]),
            .tag_q     (win_tag[g]),
            .valid_q   (win_valid[g])
        ); // [R8] [R3]
    end

    // ------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= datu_pkg::S_IDLE;
        end else begin
            case (state_q)
                datu_pkg::S_IDLE: begin
                    if (in_valid && in_ready_q) begin
                        state_q <= datu_pkg::S_CHECK;
                    end
                end
                datu_pkg::S_CHECK: begin
                    if (!mapped) begin
                        state_q <= datu_pkg::S_IDLE; // [R13]
                    end else if (hit) begin
                        state_q <= datu_pkg::S_SEND;
                    end else begin
                        state_q <= datu_pkg::S_REQ; // [R15]
                    end
                end
                datu_pkg::S_REQ: begin
                    if (rd_req_ready) begin
                        state_q <= datu_pkg::S_FILL;
                    end
                end
                datu_pkg::S_FILL: begin
                    if (fill_last) begin
                        state_q <= datu_pkg::S_CHECK;
                    end
                end
                datu_pkg::S_SEND: begin
                    if (out_ready) begin
                        state_q <= datu_pkg::S_IDLE;
                    end
                end
                default: state_q <= datu_pkg::S_IDLE;
            endcase
        end
    end

    // One packet in flight keeps ordering simple at the cost of throughput
    always_ff @(posedge clk) begin
        if (!rstn) begin
            in_ready_q <= 1'b0;
            pkt_q      <= '0;
        end else if (state_q == datu_pkg::S_IDLE
                     && in_valid && in_ready_q) begin
            in_ready_q <= 1'b0;
            pkt_q      <= in_pkt; // [R3]
        end else begin
            in_ready_q <= (state_q == datu_pkg::S_IDLE)
                       || (state_q == datu_pkg::S_CHECK && !mapped)
                       || (state_q == datu_pkg::S_SEND && out_ready);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            drop_q <= 1'b0;
        end else begin
            drop_q <= (state_q == datu_pkg::S_CHECK) && !mapped; // [R13]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_req_valid_q <= 1'b0;
            rd_req_addr_q  <= '0;
            fill_cnt_q     <= '0;
        end else begin
            if (state_q == datu_pkg::S_CHECK && mapped && !hit) begin
                rd_req_valid_q <= 1'b1;
                rd_req_addr_q  <= pt_addr; // [R4] [R7]
                fill_cnt_q     <= '0;
            end else if (rd_req_valid_q && rd_req_ready) begin
                rd_req_valid_q <= 1'b0;
            end
            if (state_q == datu_pkg::S_FILL && rd_rsp_valid) begin
                fill_cnt_q <= fill_cnt_q + 3'h1; // [R8]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            out_q <= '0;
        end else if (state_q == datu_pkg::S_CHECK && mapped && hit) begin
            out_q.paddr <= paddr; // [R1]
            out_q.tc    <= pkt_q.tc;
            out_q.route <= tc_route_sel[pkt_q.tc]; // [R12]
            out_q.data  <= pkt_q.data;
            out_q.last  <= pkt_q.last;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            out_valid <= 1'b0;
        end else if (state_q == datu_pkg::S_CHECK && mapped && hit) begin
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    assign in_ready     = in_ready_q;
    assign out_pkt      = out_q;
    assign rd_req_valid = rd_req_valid_q;
    assign rd_req_addr  = rd_req_addr_q;
    assign drop_event   = drop_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_last_beat;
        state_q == datu_pkg::S_FILL && fill_last;
    endsequence
    sequence s_recheck;
        state_q == datu_pkg::S_CHECK ##1 state_q == datu_pkg::S_SEND;
    endsequence

    a_fill_then_hit: assert property (s_last_beat |=> s_recheck) // [R8] [R9]
        else $error("Refilled window did not hit");
    a_drop_unmapped: assert property ( // [R13]
        (state_q == datu_pkg::S_CHECK && !mapped)
        |=> drop_q && !out_valid ##1 !drop_q)
        else $error("Unmapped class not dropped once");
    a_miss_stalls: assert property ( // [R15]
        (state_q == datu_pkg::S_CHECK && mapped && !hit)
        |=> rd_req_valid_q && !out_valid)
        else $error("Miss did not stall and fetch");
    a_offset_kept: assert property ( // [R6]
        out_valid |-> out_q.paddr[11:0] == pkt_q.laddr[11:0])
        else $error("In-page offset changed");
    a_legacy_high: assert property ( // [R2]
        $rose(out_valid) && $past(addr32_mode) |-> out_q.paddr[63:32] == '0)
        else $error("Legacy mode upper bits set");
    a_req_pointer: assert property ( // [R4] [R10]
        $rose(rd_req_valid_q) && !addr32_mode |-> rd_req_addr_q[63:12]
            == ptp_q[pkt_q.vch][pkt_q.laddr[23:21]] && rd_req_addr_q[5:0] == '0)
        else $error("Table fetch address wrong");
    // The refilled window must now carry the new buffer's tag
    a_buf_switch: assert property ( // [R9]
        s_last_beat |=> win_valid[pkt_q.vch]
            && win_tag[pkt_q.vch] == need_tag)
        else $error("Stale buffer entries used");
    a_route_held: assert property ( // [R12]
        out_valid && !out_ready |=> out_valid && $stable(out_q))
        else $error("Output packet changed while waiting");
    a_ready_idle: assert property ( // [R3]
        in_ready_q |-> state_q == datu_pkg::S_IDLE)
        else $error("Packet taken while busy");
endmodule
`default_nettype wire
